// ---- logic/offer_pkg.sv ----
// constants and carriers for the negotiation offer register block
// assumes a 32-bit avalon-mm slave at word addresses, one clock
package offer_pkg;
	localparam logic [7:0]  OFFER_ADDR     = 8'h04;
	localparam logic [7:0]  NP_TX_ADDR     = 8'h07;
	localparam logic [7:0]  PARTNER_ADDR   = 8'h05;
	localparam logic [7:0]  EXPANSION_ADDR = 8'h06;
	localparam logic [7:0]  CONTROL_ADDR   = 8'h10;
	localparam int          NP_BIT         = 15;
	localparam int          ACK_BIT        = 14;
	localparam int          RF_BIT         = 13;
	localparam int          TECH_HI        = 12;
	localparam int          TECH_LO        = 5;
	localparam int          PAUSE_BIT      = 10;
	localparam int          T4_BIT         = 9;
	localparam int          EXP_PAGE_CAP   = 3;
	localparam int          EXP_PAGE_RX    = 1;
	localparam logic [15:0] OFFER_RESET    = 16'h0001;
	localparam logic [15:0] NP_TX_RESET    = 16'h0000;
	localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} bus_req_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_ANS   = 3'b100
	} bus_state_t;
endpackage : offer_pkg

// ---- logic/sync2.sv ----
// two-flop synchroniser for a level or a word held steady around its strobe
// assumes the input is asynchronous to clk
module sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// level
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : sync2

// ---- logic/negotiation_offer.sv ----
// negotiation offer register with next-page transmit and partner status
// assumes the negotiation engine runs on another clock: its pins are synced
// Function
// - Setting bit 15 of the offer word asks the partner for next pages.
// - The partner's next-page ability reads back in the expansion word.
// - A requested next page waits until software writes the page word.
// - Bit 15 of the offer word resets to zero.
// - Bit 13 advertises a remote fault and resets to zero.
// - Bits 12 to 5 are sent to the partner as the ability field.
// - Bits 12 and 11 reset to zero yet stay writable and are sent.
// - Bit 10 offers pause, resets to zero, and changes no mode here.
// - Bits 8 to 5 offer the four twisted-pair speed and duplex modes.
// - The selector field in bits 4 to 0 resets to 00001.
//
// Our own choice: register access over Avalon-MM.
module negotiation_offer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// avalon-mm slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// negotiation engine side
	input  wire logic        partner_page_capable,
	input  wire logic        partner_page_pending,
	input  wire logic        partner_page_valid,
	input  wire logic [15:0] partner_page_word,
	input  wire logic        page_taken,
	output logic      [15:0] offer_word,
	output logic      [15:0] next_page_word,
	output logic             next_page_ready
);
	logic [15:0] offer_r, offer_nxt;
	logic [15:0] np_tx_r, np_tx_nxt;
	logic        np_ready_r, np_ready_nxt;
	logic [15:0] partner_r;
	logic        page_rx_r;
	logic        cap_s, pend_s, valid_s, taken_s, valid_d_r;
	logic [15:0] word_s;
	logic [31:0] rdata_nxt;
	offer_pkg::bus_state_t state_r, state_nxt;

	sync2 u_cap (.clk(clk), .nrst(nrst), .d(partner_page_capable),
		.q(cap_s));
	sync2 u_pend (.clk(clk), .nrst(nrst), .d(partner_page_pending),
		.q(pend_s));
	sync2 u_valid (.clk(clk), .nrst(nrst), .d(partner_page_valid),
		.q(valid_s));
	sync2 u_taken (.clk(clk), .nrst(nrst), .d(page_taken), .q(taken_s));
	// word settles before valid rises, so both arrive through equal stages
	sync2 #(.WIDTH(16)) u_word (.clk(clk), .nrst(nrst),
		.d(partner_page_word), .q(word_s));

	// two wait cycles (the request cycle and ST_WAIT), then the answer: bus sees waitrequest low once
	wire idle_req  = (state_r == offer_pkg::ST_IDLE) && (read || write);
	wire answering = (state_r == offer_pkg::ST_ANS);
	wire do_write  = answering && write;
	wire do_read   = answering && read;
	wire hit_offer = address == offer_pkg::OFFER_ADDR;
	wire hit_np    = address == offer_pkg::NP_TX_ADDR;
	wire hit_lp    = address == offer_pkg::PARTNER_ADDR;
	wire hit_exp   = address == offer_pkg::EXPANSION_ADDR;
	wire partner_load = valid_s && !valid_d_r;
	wire rx_clear = do_read && hit_exp;

	// ack bit never stored: forced to zero both ways
	wire [15:0] offer_wr = {writedata[15], 1'b0, writedata[13:0]};
	assign offer_nxt = (do_write && hit_offer) ? offer_wr : offer_r;

	// a page word written arms the transmit; engine's take ends it
	assign np_tx_nxt = (do_write && hit_np) ? writedata[15:0] : np_tx_r;
	assign np_ready_nxt = (do_write && hit_np) ? 1'b1 :
		(taken_s ? 1'b0 : np_ready_r);

	wire [15:0] exp_word = {12'h000, cap_s, 1'b0, page_rx_r, pend_s};
	assign rdata_nxt =
		hit_offer ? {16'h0000, offer_r[15], 1'b0, offer_r[13:0]} :
		hit_np    ? {16'h0000, np_tx_r} :
		hit_lp    ? {16'h0000, partner_r} :
		hit_exp   ? {16'h0000, exp_word} : offer_pkg::UNMAPPED_DATA;

	always_comb begin
		case (state_r)
			offer_pkg::ST_IDLE: state_nxt = idle_req ? offer_pkg::ST_WAIT
				: offer_pkg::ST_IDLE;
			offer_pkg::ST_WAIT: state_nxt = offer_pkg::ST_ANS;
			offer_pkg::ST_ANS:  state_nxt = offer_pkg::ST_IDLE;
			default:            state_nxt = offer_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r     <= offer_pkg::ST_IDLE;
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else begin
			state_r     <= state_nxt;
			waitrequest <= !(state_nxt == offer_pkg::ST_ANS);
			readdata    <= (state_nxt == offer_pkg::ST_ANS) ? rdata_nxt
				: 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			offer_r    <= offer_pkg::OFFER_RESET;
			np_tx_r    <= offer_pkg::NP_TX_RESET;
			np_ready_r <= 1'b0;
		end else begin
			offer_r    <= offer_nxt;
			np_tx_r    <= np_tx_nxt;
			np_ready_r <= np_ready_nxt;
		end
	end

	// partner page lands here; received flag set beats read clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			partner_r <= 16'h0000;
			page_rx_r <= 1'b0;
			valid_d_r <= 1'b0;
		end else begin
			valid_d_r <= valid_s;
			if (partner_load)
				partner_r <= word_s;
			page_rx_r <= partner_load || (page_rx_r && !rx_clear);
		end
	end

	// pause and speed bits only travel in the word, no mode logic
	always_ff @(posedge clk) begin
		if (!nrst) begin
			offer_word      <= offer_pkg::OFFER_RESET;
			next_page_word  <= offer_pkg::NP_TX_RESET;
			next_page_ready <= 1'b0;
		end else begin
			offer_word      <= offer_r;
			next_page_word  <= np_tx_r;
			next_page_ready <= np_ready_r;
		end
	end

	// offer word: reset, storage and the copy sent out
	a_offer_reset: assert property (
		@(posedge clk)
		$rose(nrst) |-> offer_r == offer_pkg::OFFER_RESET)
		else $error("offer word not at reset value");
	a_ack_zero: assert property (
		@(posedge clk) disable iff (!nrst)
		offer_r[offer_pkg::ACK_BIT] == 1'h0)
		else $error("ack bit stored");
	a_write_offer: assert property (
		@(posedge clk) disable iff (!nrst)
		do_write && hit_offer |=> ##1
		offer_word[15] == $past(writedata[15], 2) &&
		offer_word[13:0] == $past(writedata[13:0], 2))
		else $error("offer write not sent out");
	a_offer_hold: assert property (
		@(posedge clk) disable iff (!nrst)
		!(do_write && hit_offer) |=> $stable(offer_r))
		else $error("offer word changed without a write");
	a_offer_out: assert property (
		@(posedge clk) disable iff (!nrst)
		offer_word == $past(offer_r))
		else $error("sent offer word does not follow register");

	// bus answer timed from the request cycle, read data checked in the answer cycle
	a_bus_answer: assert property (
		@(posedge clk) disable iff (!nrst)
		idle_req |=> waitrequest ##1 !waitrequest ##1 waitrequest)
		else $error("bus answer timing wrong");
	a_offer_read: assert property (
		@(posedge clk) disable iff (!nrst)
		do_read && hit_offer |-> readdata[15:0] ==
		{$past(offer_r[15]), 1'h0, $past(offer_r[13:0])})
		else $error("offer word read back wrong");
	a_cap_read: assert property (
		@(posedge clk) disable iff (!nrst)
		do_read && hit_exp |->
		readdata[offer_pkg::EXP_PAGE_CAP] == $past(cap_s))
		else $error("capability not reported");
	a_pend_read: assert property (
		@(posedge clk) disable iff (!nrst)
		do_read && hit_exp |-> readdata[0] == $past(pend_s))
		else $error("partner request not reported");
	a_np_read: assert property (
		@(posedge clk) disable iff (!nrst)
		do_read && hit_np |-> readdata[15:0] == $past(np_tx_r))
		else $error("page word read back wrong");
	a_lp_read: assert property (
		@(posedge clk) disable iff (!nrst)
		do_read && hit_lp |-> readdata[15:0] == $past(partner_r))
		else $error("partner page read back wrong");
	a_unmapped: assert property (
		@(posedge clk) disable iff (!nrst)
		do_read && !(hit_offer || hit_np || hit_lp || hit_exp)
		|-> readdata == offer_pkg::UNMAPPED_DATA)
		else $error("unmapped read not zero");

	// next-page transmit handshake and the partner page
	a_np_arm: assert property (
		@(posedge clk) disable iff (!nrst)
		do_write && hit_np |=> ##1 next_page_ready)
		else $error("next page not armed");
	a_np_word: assert property (
		@(posedge clk) disable iff (!nrst)
		do_write && hit_np |=> ##1
		next_page_word == $past(writedata[15:0], 2))
		else $error("next page word not sent out");
	a_np_release: assert property (
		@(posedge clk) disable iff (!nrst)
		taken_s && !(do_write && hit_np) |=> !np_ready_r)
		else $error("taken page still offered");
	a_rx_sticky: assert property (
		@(posedge clk) disable iff (!nrst)
		partner_load |=> page_rx_r)
		else $error("page received lost");
	a_partner_land: assert property (
		@(posedge clk) disable iff (!nrst)
		partner_load |=> partner_r == $past(word_s))
		else $error("partner page not captured");
	a_rx_clear: assert property (
		@(posedge clk) disable iff (!nrst)
		rx_clear && !partner_load |=> !page_rx_r)
		else $error("page received not cleared on read");

	// main scenarios the bench is expected to reach
	c_offer_write: cover property (@(posedge clk) do_write && hit_offer);
	c_np_write: cover property (@(posedge clk) do_write && hit_np);
	c_partner_page: cover property (@(posedge clk) partner_load);
	c_rx_clear: cover property (@(posedge clk) rx_clear && page_rx_r);
	c_page_taken: cover property (@(posedge clk) taken_s && np_ready_r);
endmodule : negotiation_offer

// ---- verif/link_partner_model.sv ----
// model of the negotiation engine and far partner facing the offer block
// assumes the bench clock; the partner page comes from the bench
module link_partner_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// bench control
	input  wire logic        slow,
	input  wire logic [15:0] page_in,
	// block side
	input  wire logic        next_page_ready,
	output logic             cap,
	output logic             pend,
	output logic             pval,
	output logic             taken,
	output logic      [15:0] word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{cap, pend, pval, taken, cnt_r} <= '0;
			word <= 16'hA5A5;
		end else begin
			cap <= 1'b1;
			pend <= 1'b1;
			cnt_r <= (next_page_ready && !taken) ? cnt_r + 4'h1 : 4'h0;
			// slow mode stalls the page load to stretch the wait
			if (cnt_r == (slow ? 4'h8 : 4'h1)) begin
				taken <= 1'b1;
				pval <= 1'b1;
				word <= page_in;
			end else if (taken && !next_page_ready) begin
				taken <= 1'b0;
				pval <= 1'b0;
				// released word never keeps its last value
				word <= ~word;
			end
		end
	end
endmodule : link_partner_model

// ---- verif/negotiation_offer_tb_top.sv ----
// bench for the negotiation offer register block
// assumes offer_pkg and link_partner_model are compiled first
module negotiation_offer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, nrst = 0, read = 0, write = 0, slow = 0;
	logic [7:0]  address = 8'h00;
	logic [31:0] writedata = 32'h0, readdata;
	logic [15:0] page_in = 16'h0, offer_word, np_word, p_word, v, last_v;
	logic        waitrequest, cap, pend, pval, taken, np_ready;
	int          num_errors = 0, comparisons = 0;
	logic [31:0] exp_q[$];
	always #2.5 clk = ~clk;
	negotiation_offer u_negotiation_offer (.clk(clk), .nrst(nrst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .partner_page_capable(cap),
		.partner_page_pending(pend), .partner_page_valid(pval),
		.partner_page_word(p_word), .page_taken(taken),
		.offer_word(offer_word), .next_page_word(np_word),
		.next_page_ready(np_ready));
	link_partner_model u_link_partner_model (.clk(clk), .nrst(nrst),
		.slow(slow), .page_in(page_in), .next_page_ready(np_ready),
		.cap(cap), .pend(pend), .pval(pval), .taken(taken), .word(p_word));
	task automatic check(string nm, logic [31:0] seen, logic [31:0] e);
		comparisons++;
		if (seen !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, e, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
		int n = 0;
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest && n < 50);
		if (n >= 50) begin
			num_errors++;
			close_out();
		end
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd(logic [7:0] a, logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 16'h0000);
	endtask : rd
	task automatic wait_np(logic lvl);
		int n = 0;
		while (np_ready !== lvl && n < 40) begin
			@(posedge clk);
			n++;
		end
		check("next_page_ready", {31'h0, np_ready}, {31'h0, lvl});
		if (np_ready !== lvl)
			close_out();
	endtask : wait_np
	// every answered read is matched against the oldest expectation
	always @(posedge clk) if (read && !waitrequest)
		check("readdata", readdata, exp_q.pop_front());
	initial begin
		void'($urandom(17407));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		check("offer_word", {16'h0, offer_word}, 32'h1);
		rd(8'h04, 32'h0000_0001);
		bus(1'b1, 8'h04, 16'hFFFF);
		rd(8'h04, 32'h0000_BFFF);
		$display("test reset and fields done");
		for (int i = 0; i < 4; i++) begin
			// software keeps the reserved handshake and unsupported bits clear
			v = 16'($urandom) & 16'hBDFF;
			v[15] = i[0];
			bus(1'b1, 8'h04, v);
			last_v = v;
			repeat (2) @(posedge clk);
			check("offer_word", {16'h0, offer_word}, {16'h0, v});
			rd(8'h04, {16'h0, v});
		end
		$display("test offer writes done");
		rd(8'h06, 32'h0000_0009);
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			page_in <= 16'($urandom);
			v = 16'($urandom);
			bus(1'b1, 8'h07, v);
			// the page word output follows its register one edge later
			@(posedge clk);
			check("next_page_word", {16'h0, np_word}, {16'h0, v});
			wait_np(1'b1);
			wait_np(1'b0);
			rd(8'h05, {16'h0, page_in});
			rd(8'h06, 32'h0000_000B);
			rd(8'h06, 32'h0000_0009);
		end
		$display("test next page done");
		// software gives up on next pages: rewrite the offer word with the request clear
		last_v[15] = 1'h0;
		bus(1'b1, 8'h04, last_v);
		repeat (2) @(posedge clk);
		check("offer_word", {16'h0, offer_word}, {16'h0, last_v});
		bus(1'b1, 8'h20, 16'hFFFF);
		rd(8'h20, 32'h0);
		rd(8'h04, {16'h0, last_v});
		$display("test unmapped done");
		close_out();
	end
endmodule : negotiation_offer_tb_top
